// File: rtl/irq_ctrl_pkg.sv
// package: register map, vector table and timing constants for the interrupt controller
package irq_ctrl_pkg;
    localparam int NUM_SRC = 20;
    localparam int SRC_W = 5;
    localparam int NUM_EXT = 13;
    localparam int NUM_AUX = 4;
    localparam logic [7:0] GLOBAL_SOURCE_MASK_ADDR = 8'hA8;
    localparam logic [7:0] GLOBAL_SOURCE_MASK_RESET = 8'h00;
    localparam logic [7:0] PRIORITY_LOW_BITS_ADDR = 8'hB8;
    localparam logic [7:0] PRIORITY_HIGH_BITS_ADDR = 8'hF2;
    localparam logic [7:0] EXT_ENABLE1_ADDR = 8'hE6;
    localparam logic [7:0] EXT_ENABLE2_ADDR = 8'hE7;
    localparam logic [7:0] EXT_PRIO_LOW1_ADDR = 8'hF3;
    localparam logic [7:0] EXT_PRIO_LOW2_ADDR = 8'hF4;
    localparam logic [7:0] EXT_PRIO_HIGH1_ADDR = 8'hF5;
    localparam logic [7:0] EXT_PRIO_HIGH2_ADDR = 8'hF6;
    localparam logic [7:0] PENDING_SET0_ADDR = 8'hF7;
    localparam logic [7:0] PENDING_SET1_ADDR = 8'hF9;
    localparam logic [7:0] PENDING_SET2_ADDR = 8'hFA;
    localparam logic [7:0] PRIORITY_RESET = 8'h00;
    localparam logic [7:0] RESERVED_PRIO_READ = 8'h80;
    localparam int GLOBAL_GATE_BIT = 7;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] FIRST_VECTOR = 16'h0003;
    localparam logic [15:0] VECTOR_STEP = 16'h0008;
    localparam int DETECT_CYCLES = 1;
    localparam int CALL_CYCLES = 4;
    localparam int FASTEST_RESPONSE = DETECT_CYCLES + CALL_CYCLES;
    localparam int RETURN_CYCLES = 5;
    localparam int DIVIDE_CYCLES = 8;
    localparam int WORST_RESPONSE = DETECT_CYCLES + RETURN_CYCLES + DIVIDE_CYCLES + CALL_CYCLES;

    typedef enum logic [1:0] {LEVEL0, LEVEL1, LEVEL2, LEVEL3} level_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic valid;
        logic [SRC_W-1:0] src;
        logic [1:0] level;
        logic [15:0] vector;
    } vec_req_t;

    // vector address of source n: 0x0003 + 8*n
    function automatic logic [15:0] vector_of(input logic [SRC_W-1:0] n);
        vector_of = FIRST_VECTOR + {8'h00, n, 3'b000};
    endfunction
endpackage

// File: rtl/irq_arbiter.sv
// arbiter: picks the highest priority request, lowest source number on ties
module irq_arbiter
    import irq_ctrl_pkg::*;
#(
    parameter int N = NUM_SRC
)
(
    input wire logic [N-1:0] req,
    input wire logic [2*N-1:0] prio,
    output logic found,
    output logic [SRC_W-1:0] win_src,
    output logic [1:0] win_level
);
    always_comb
    begin
        found = 1'b0;
        win_src = '0;
        win_level = 2'b00;
        // scan high to low so equal levels resolve to the lowest number
        for (int i = N - 1; i >= 0; i--)
        begin
            if (req[i] && (!found || prio[2*i +: 2] >= win_level))
            begin
                found = 1'b1;
                win_src = SRC_W'(i);
                win_level = prio[2*i +: 2];
            end
        end
    end
endmodule

// File: rtl/four_level_interrupt_controller.sv
// four-level prioritised interrupt controller with vector request and nesting tracking
// Operation
// - pending flag sets on any valid event
// - enabled pending source requests long vector call
// - disabled source pending produces no request
// - global gate zero masks every source
// - flag still set after return re-requests
// - software pending write acts as event
// - two priority bits decode four levels
// - all priority bits reset to zero
// - preempt only by strictly higher level
// - ties go to lower vector number
// - sample every cycle, fastest five cycles
// - one instruction runs after a return
// - worst case response eighteen cycles
// - after exit next highest pending wins
// - vectors fixed, spaced eight from 0x0003
// - each source has own enable bit
// - return ends current priority level
module four_level_interrupt_controller
#(
    parameter int N = irq_ctrl_pkg::NUM_SRC
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clock_en,
    input wire irq_ctrl_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire logic [N-1:0] event_pulse,
    input wire logic [N-1:0] flag_clear,
    input wire logic [irq_ctrl_pkg::NUM_AUX-1:0] aux_flag,
    input wire logic [irq_ctrl_pkg::NUM_AUX-1:0] aux_enable,
    input wire logic [irq_ctrl_pkg::NUM_AUX*irq_ctrl_pkg::SRC_W-1:0] aux_src,
    input wire logic instr_done,
    input wire logic return_done,
    input wire logic vector_ack,
    output irq_ctrl_pkg::vec_req_t vec_req,
    output logic [N-1:0] pending,
    output logic [3:0] active_levels
);
    import irq_ctrl_pkg::*;

    // write strobe aimed at one register address
    function automatic logic write_hit(input reg_req_t r, input logic [7:0] a);
        write_hit = r.wr && r.addr == a;
    endfunction

    // one-hot mask of a priority level
    function automatic logic [3:0] level_bit(input logic [1:0] l);
        level_bit = 4'h1 << l;
    endfunction

    logic [7:0] global_source_mask;
    logic [7:0] priority_low_bits;
    logic [7:0] priority_high_bits;
    logic [15:0] extended_enable_regs;
    logic [15:0] extended_priority_low_regs;
    logic [15:0] extended_priority_high_regs;
    logic [3:0] active;
    logic hold_one;

    // source order: 0 ext0,1 t0,2 ext1,3 t1,4 uart,5 t2,6 spi, 7..19 extended
    wire logic [19:0] enable_vec = {extended_enable_regs[12:0], global_source_mask[0], global_source_mask[1],
        global_source_mask[2], global_source_mask[3], global_source_mask[4], global_source_mask[5],
        global_source_mask[6]};
    wire logic [19:0] low_vec = {extended_priority_low_regs[12:0], priority_low_bits[6:0]};
    wire logic [19:0] high_vec = {extended_priority_high_regs[12:0], priority_high_bits[6:0]};
    wire logic [19:0] enable_ord;
    wire logic [39:0] prio_vec;

    genvar g;
    generate
        for (g = 0; g < 20; g++)
        begin : g_map
            if (g < 7)
            begin : g_basic
                assign enable_ord[g] = enable_vec[6 - g];
            end
            else
            begin : g_ext
                assign enable_ord[g] = enable_vec[g];
            end
            assign prio_vec[2*g +: 2] = {high_vec[g], low_vec[g]};
        end
    endgenerate

    // auxiliary flag groups fold into their source
    logic [N-1:0] aux_req;
    always_comb
    begin
        aux_req = '0;
        for (int k = 0; k < NUM_AUX; k++)
        begin
            if (aux_flag[k] && aux_enable[k])
            begin
                aux_req[aux_src[k*SRC_W +: SRC_W]] = 1'b1;
            end
        end
    end

    // software write-one into pending set registers
    wire logic wr_set0 = write_hit(reg_req, PENDING_SET0_ADDR);
    wire logic wr_set1 = write_hit(reg_req, PENDING_SET1_ADDR);
    wire logic wr_set2 = write_hit(reg_req, PENDING_SET2_ADDR);
    wire logic [23:0] sw_set_full = {wr_set2 ? reg_req.wdata : 8'h00, wr_set1 ? reg_req.wdata : 8'h00,
        wr_set0 ? reg_req.wdata : 8'h00};
    wire logic [N-1:0] sw_set = sw_set_full[N-1:0];

    // hardware and software sets win over clears
    wire logic [N-1:0] next_pending = (pending & ~flag_clear) | event_pulse | sw_set;

    wire logic gate = global_source_mask[GLOBAL_GATE_BIT];
    // masked sources give no request at all
    wire logic [N-1:0] live_req = gate ? ((pending | aux_req) & enable_ord[N-1:0]) : '0;

    logic found;
    logic [SRC_W-1:0] win_src;
    logic [1:0] win_level;

    irq_arbiter #(.N(N)) u_arbiter (
        .req(live_req),
        .prio(prio_vec[2*N-1:0]),
        .found(found),
        .win_src(win_src),
        .win_level(win_level)
    );

    // highest level currently in service; none leaves top_active at 0 with in_service low
    logic in_service;
    logic [1:0] top_active;
    always_comb
    begin
        in_service = |active;
        top_active = 2'b00;
        for (int l = 0; l < 4; l++)
        begin
            if (active[l])
            begin
                top_active = 2'(l);
            end
        end
    end

    // strictly higher level than any in service, nothing preempts level 3
    wire logic may_preempt = !in_service || (win_level > top_active);
    wire logic may_request = found && may_preempt && !hold_one && !vec_req.valid;
    wire logic [1:0] clear_mask_lvl = top_active;

    // register writes
    wire logic wr_ie = write_hit(reg_req, GLOBAL_SOURCE_MASK_ADDR);
    wire logic wr_ipl = write_hit(reg_req, PRIORITY_LOW_BITS_ADDR);
    wire logic wr_iph = write_hit(reg_req, PRIORITY_HIGH_BITS_ADDR);
    wire logic wr_ee1 = write_hit(reg_req, EXT_ENABLE1_ADDR);
    wire logic wr_ee2 = write_hit(reg_req, EXT_ENABLE2_ADDR);
    wire logic wr_epl1 = write_hit(reg_req, EXT_PRIO_LOW1_ADDR);
    wire logic wr_epl2 = write_hit(reg_req, EXT_PRIO_LOW2_ADDR);
    wire logic wr_eph1 = write_hit(reg_req, EXT_PRIO_HIGH1_ADDR);
    wire logic wr_eph2 = write_hit(reg_req, EXT_PRIO_HIGH2_ADDR);

    logic [7:0] next_rdata;
    always_comb
    begin
        unique case (reg_req.addr)
            GLOBAL_SOURCE_MASK_ADDR: next_rdata = global_source_mask;
            PRIORITY_LOW_BITS_ADDR: next_rdata = priority_low_bits | RESERVED_PRIO_READ;
            PRIORITY_HIGH_BITS_ADDR: next_rdata = priority_high_bits | RESERVED_PRIO_READ;
            EXT_ENABLE1_ADDR: next_rdata = extended_enable_regs[7:0];
            EXT_ENABLE2_ADDR: next_rdata = extended_enable_regs[15:8];
            EXT_PRIO_LOW1_ADDR: next_rdata = extended_priority_low_regs[7:0];
            EXT_PRIO_LOW2_ADDR: next_rdata = extended_priority_low_regs[15:8];
            EXT_PRIO_HIGH1_ADDR: next_rdata = extended_priority_high_regs[7:0];
            EXT_PRIO_HIGH2_ADDR: next_rdata = extended_priority_high_regs[15:8];
            PENDING_SET0_ADDR: next_rdata = pending[7:0];
            PENDING_SET1_ADDR: next_rdata = pending[15:8];
            PENDING_SET2_ADDR: next_rdata = {4'h0, pending[19:16]};
            default: next_rdata = 8'h00;
        endcase
    end

    // basic enable register, global gate in bit 7
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            global_source_mask <= GLOBAL_SOURCE_MASK_RESET;
        else if (clock_en && wr_ie)
            global_source_mask <= reg_req.wdata;
    end

    // low priority bits, bit 7 reserved
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            priority_low_bits <= PRIORITY_RESET;
        else if (clock_en && wr_ipl)
            priority_low_bits <= {1'b0, reg_req.wdata[6:0]};
    end

    // high priority bits, bit 7 reserved
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            priority_high_bits <= PRIORITY_RESET;
        else if (clock_en && wr_iph)
            priority_high_bits <= {1'b0, reg_req.wdata[6:0]};
    end

    // extended enables, upper byte holds five sources
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            extended_enable_regs <= '0;
        else if (clock_en && wr_ee1)
            extended_enable_regs[7:0] <= reg_req.wdata;
        else if (clock_en && wr_ee2)
            extended_enable_regs[15:8] <= {3'b000, reg_req.wdata[4:0]};
    end

    // extended low priority bits
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            extended_priority_low_regs <= '0;
        else if (clock_en && wr_epl1)
            extended_priority_low_regs[7:0] <= reg_req.wdata;
        else if (clock_en && wr_epl2)
            extended_priority_low_regs[15:8] <= {3'b000, reg_req.wdata[4:0]};
    end

    // extended high priority bits
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            extended_priority_high_regs <= '0;
        else if (clock_en && wr_eph1)
            extended_priority_high_regs[7:0] <= reg_req.wdata;
        else if (clock_en && wr_eph2)
            extended_priority_high_regs[15:8] <= {3'b000, reg_req.wdata[4:0]};
    end

    // read data holds until the next read strobe
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (clock_en && reg_req.rd)
            reg_rdata <= next_rdata;
    end

    // pending flags follow their next value every enabled cycle
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            pending <= '0;
        else if (clock_en)
            pending <= next_pending;
    end

    // one instruction must finish after a return before a new request
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            hold_one <= 1'b0;
        else if (clock_en && return_done)
            hold_one <= 1'b1;
        else if (clock_en && instr_done)
            hold_one <= 1'b0;
    end

    // a return ends the top level in service, an accepted vector opens its level
    wire logic accept = vec_req.valid && vector_ack;
    wire logic [3:0] end_mask = return_done ? level_bit(clear_mask_lvl) : 4'h0;
    wire logic [3:0] start_mask = accept ? level_bit(vec_req.level) : 4'h0;
    wire logic [3:0] next_active = (active & ~end_mask) | start_mask;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            active <= 4'h0;
        else if (clock_en)
            active <= next_active;
    end

    // the request stands until the processor accepts it
    wire logic raise = may_request && !return_done;
    wire vec_req_t next_vec = '{valid: 1'b1, src: win_src, level: win_level, vector: vector_of(win_src)};
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            vec_req <= '0;
        else if (clock_en && accept)
            vec_req.valid <= 1'b0;
        else if (clock_en && raise)
            vec_req <= next_vec;
    end

    assign active_levels = active;
endmodule

// File: sim/irq_ctrl_properties.sv
// checker: port-level properties of the interrupt controller
module irq_ctrl_properties
    import irq_ctrl_pkg::*;
#(
    parameter int N = NUM_SRC
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clock_en,
    input wire irq_ctrl_pkg::reg_req_t reg_req,
    input wire logic [N-1:0] event_pulse,
    input wire logic return_done,
    input wire logic vector_ack,
    input wire irq_ctrl_pkg::vec_req_t vec_req,
    input wire logic [N-1:0] pending,
    input wire logic [3:0] active_levels
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    a_req_stands: assert property (vec_req.valid && !vector_ack |=> vec_req.valid)
        else $error("request dropped before ack");
    a_ack_clears: assert property (vec_req.valid && vector_ack && clock_en |=> !vec_req.valid)
        else $error("request kept after ack");
    a_ack_level: assert property (vec_req.valid && vector_ack && clock_en |=> active_levels[$past(vec_req.level)])
        else $error("level not marked in service");
    a_event_sets: assert property (clock_en && |event_pulse |=> (pending & $past(event_pulse)) == $past(event_pulse))
        else $error("event did not set pending");
    a_vector_table: assert property (vec_req.valid |-> vec_req.vector == FIRST_VECTOR + {8'h00, vec_req.src, 3'b000})
        else $error("wrong vector address");
    a_strictly_higher: assert property ($rose(vec_req.valid) |-> (active_levels >> vec_req.level) == 4'h0)
        else $error("request not above levels in service");
    a_return_pops: assert property (return_done && clock_en && !vector_ack && active_levels != 4'h0
        |=> $countones(active_levels) + 1 == $countones($past(active_levels)))
        else $error("return did not end one level");
    a_return_waits: assert property (return_done && clock_en && !vec_req.valid |=> !vec_req.valid)
        else $error("request raised during return");
    a_soft_set: assert property (clock_en && reg_req.wr && reg_req.addr == PENDING_SET0_ADDR
        |=> (pending[7:0] & $past(reg_req.wdata)) == $past(reg_req.wdata))
        else $error("software set ignored");
endmodule
bind four_level_interrupt_controller irq_ctrl_properties #(.N(N)) i_props (.clock, .rst_n, .clock_en, .reg_req,
    .event_pulse, .return_done, .vector_ack, .vec_req, .pending, .active_levels);

// File: sim/cpu_stub.sv
// processor stand-in: takes vector requests and performs returns on command
module cpu_stub
(
    input wire logic clock,
    input wire logic rst_n,
    input wire irq_ctrl_pkg::vec_req_t vec_req,
    input wire logic hold_ack,
    input wire logic ret_cmd,
    output logic vector_ack,
    output logic return_done,
    output logic instr_done
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vector_ack <= 1'b0;
            return_done <= 1'b0;
            instr_done <= 1'b0;
        end
        else
        begin
            vector_ack <= vec_req.valid && !vector_ack && !hold_ack;
            return_done <= ret_cmd;
            instr_done <= return_done; // one instruction after the return
        end
    end
endmodule

// File: sim/tb_four_level_interrupt_controller.sv
// testbench: register and event driven checks of the interrupt controller
module tb_four_level_interrupt_controller;
    timeunit 1ns;
    timeprecision 1ps;
    import irq_ctrl_pkg::*;
    logic clock = 0, rst_n = 0, clock_en = 1, hold_ack = 0, ret_cmd = 0, instr_done, return_done, vector_ack;
    reg_req_t reg_req = '0;
    logic [7:0] reg_rdata;
    logic [19:0] event_pulse = '0, flag_clear = '0, aux_src = 20'h00007, pending;
    logic [3:0] aux_flag = '0, aux_enable = '0, active_levels;
    vec_req_t vec_req;
    int error_cnt = 0, n_compared = 0;
    four_level_interrupt_controller i_dut (.clock, .rst_n, .clock_en, .reg_req, .reg_rdata, .event_pulse,
        .flag_clear, .aux_flag, .aux_enable, .aux_src, .instr_done, .return_done, .vector_ack, .vec_req,
        .pending, .active_levels);
    cpu_stub i_cpu (.clock, .rst_n, .vec_req, .hold_ack, .ret_cmd, .vector_ack, .return_done, .instr_done);
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_req <= '{a, d, 1'b1, 1'b0};
        tick(1);
        reg_req <= '0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_req <= '{a, 8'h00, 1'b0, 1'b1};
        tick(1);
        reg_req <= '0;
        tick(1);
        check(reg_rdata, exp);
    endtask
    task automatic pulse(input logic [19:0] ev);
        event_pulse <= ev;
        tick(1);
        event_pulse <= '0;
        tick(1);
    endtask
    task automatic clr(input logic [19:0] m);
        flag_clear <= m;
        tick(1);
        flag_clear <= '0;
        tick(1);
    endtask
    task automatic ret;
        ret_cmd <= 1'b1;
        tick(1);
        ret_cmd <= 1'b0;
    endtask
    // waits for a request and checks its source and vector
    task automatic await_req(input logic [4:0] s);
        int n = 0;
        while (vec_req.valid !== 1'b1 && n < 30)
        begin
            tick(1);
            n++;
        end
        check({vec_req.valid, vec_req.src, vec_req.vector}, {1'b1, s, FIRST_VECTOR + {8'h00, s, 3'b000}});
    endtask
    initial
    begin
        forever #5 clock = ~clock;
    end
    initial
    begin
        #20000;
        error_cnt++;
        end_sim;
    end
    initial
    begin
        tick(6);
        rst_n = 1;
        tick(1);
        rd(GLOBAL_SOURCE_MASK_ADDR, GLOBAL_SOURCE_MASK_RESET);
        rd(PRIORITY_HIGH_BITS_ADDR, RESERVED_PRIO_READ);
        rd(8'h00, 8'h00);
        $display("reset test done");
        wr(GLOBAL_SOURCE_MASK_ADDR, 8'h02);
        hold_ack <= 1'b1;
        pulse(20'h3);
        check(pending[1:0], 2'b11);
        check(vec_req.valid, 1'b0);
        wr(GLOBAL_SOURCE_MASK_ADDR, 8'h82);
        tick(3);
        await_req(5'd1);
        hold_ack <= 1'b0;
        clr(20'h3);
        tick(2);
        check(active_levels, 4'h1);
        ret;
        tick(4);
        check({vec_req.valid, active_levels}, 5'h00);
        $display("gate test done");
        rd(PRIORITY_HIGH_BITS_ADDR, RESERVED_PRIO_READ);
        wr(GLOBAL_SOURCE_MASK_ADDR, 8'hFF);
        pulse(20'h6);
        check(vec_req.valid, 1'b1);
        await_req(5'd1);
        tick(3);
        check(vec_req.valid, 1'b0);
        clr(20'h2);
        ret;
        await_req(5'd2);
        clr(20'h4);
        ret;
        tick(4);
        $display("order test done");
        wr(PRIORITY_LOW_BITS_ADDR, 8'h02);
        wr(PRIORITY_HIGH_BITS_ADDR, 8'h01);
        rd(PRIORITY_LOW_BITS_ADDR, 8'h82);
        pulse(20'h2);
        await_req(5'd1);
        tick(3);
        pulse(20'h1);
        await_req(5'd0);
        check(vec_req.level, 2'd2);
        tick(3);
        check(active_levels, 4'h6);
        pulse(20'h4);
        tick(3);
        check(vec_req.valid, 1'b0);
        clr(20'h7);
        ret;
        tick(4);
        ret;
        tick(4);
        check(active_levels, 4'h0);
        $display("priority test done");
        wr(PENDING_SET0_ADDR, 8'h08);
        await_req(5'd3);
        clr(20'h8);
        ret;
        tick(4);
        wr(EXT_ENABLE1_ADDR, 8'h01);
        aux_flag <= 4'h1;
        tick(4);
        check(vec_req.valid, 1'b0);
        aux_enable <= 4'h1;
        await_req(5'd7);
        aux_flag <= 4'h0;
        tick(3);
        ret;
        tick(4);
        check(active_levels, 4'h0);
        clock_en <= 1'b0;
        pulse(20'h10);
        check(pending[4], 1'b0);
        clock_en <= 1'b1;
        event_pulse <= 20'h10;
        flag_clear <= 20'h10;
        tick(1);
        event_pulse <= '0;
        flag_clear <= '0;
        check(pending[4], 1'b1);
        await_req(5'd4);
        clr(20'h10);
        ret;
        tick(4);
        check(active_levels, 4'h0);
        $display("source test done");
        end_sim;
    end
endmodule
